// ### src/ppcd_regs.svh
/*
  Register offsets, field positions, reset values and timing for the
  port pins and change detect block.
  Assumes an 8-bit register port with 3-bit addresses.
*/
`ifndef PPCD_REGS_SVH
`define PPCD_REGS_SVH

// Register offsets on the plain register port
`define PPCD_OFF_PB_VALUE   3'h0
`define PPCD_OFF_PB_DIR     3'h1
`define PPCD_OFF_RISE_EN    3'h2
`define PPCD_OFF_FALL_EN    3'h3
`define PPCD_OFF_CHG_FLAGS  3'h4
`define PPCD_OFF_STATUS     3'h5

// Field layout
`define PPCD_PB_LSB         4
`define PPCD_PB_W           4
`define PPCD_PA_W           6

// Reset values
`define PPCD_PB_DIR_RST     4'hf
`define PPCD_PB_LAT_RST     4'h0
`define PPCD_EN_RST         6'h00
`define PPCD_FLAG_RST       6'h00

// Synchroniser depth for pins
`define PPCD_SYNC_STAGES    2

`endif

// ### src/ppcd_pkg.sv
/*
  Types shared by the port pins and change detect block.
  Assumes the constants header is included by the users of the types.
*/
package ppcd_pkg;

  typedef logic [7:0] ppcd_byte_t;
  typedef logic [2:0] ppcd_addr_t;

  // Register selected by an access
  typedef enum logic [2:0] {
    PPCD_SEL_PB_VALUE,
    PPCD_SEL_PB_DIR,
    PPCD_SEL_RISE_EN,
    PPCD_SEL_FALL_EN,
    PPCD_SEL_CHG_FLAGS,
    PPCD_SEL_STATUS,
    PPCD_SEL_NONE
  } ppcd_sel_e;

endpackage : ppcd_pkg

// ### src/ppcd_sync.sv
/*
  Two-flop synchroniser for a group of pin levels.
  Assumes the pins are asynchronous to clk; the output is safe to use in
  the clk domain.
*/
`timescale 1ns/1ns
`include "ppcd_regs.svh"

module ppcd_sync
  import ppcd_pkg::*;
#(
  parameter int W = 1
)
(
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  // First stage is read only by the second stage
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      meta_ff <= '0;
      sync_ff <= '0;
    end
    else
    begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;

endmodule : ppcd_sync

// ### src/ppcd_top.sv
/*
  Port pins and change detect: data and direction for the upper four pins
  of the second port, and per-pin edge detection on the six first-port pins.
  Assumes one 250 MHz clock, synchronous active-low reset, pins that are
  asynchronous, and a pad ring that resolves the pin from out and enable.
*/
// What this block does
// RL1: Writes hit latch, reads return pin levels
// RL2: Only pin bits 7 to 4 implemented
// RL3: Bits 3 to 0 read zero, writes ignored
// RL4: Direction 1 is input, resets to one
// RL5: Rising enable sets flag and summary flag
// RL6: Falling enable sets flag and summary flag
// RL7: Disabled polarity never sets flag; enables reset zero
// RL8: Flag set on enabled matching edge
// RL9: Flags stay set until software writes zero
// RL10: Bits 7 and 6 read zero
// RL11: Synchronise, edge once, set beats clear
`timescale 1ns/1ns
`include "ppcd_regs.svh"

module ppcd_top
  import ppcd_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic [2:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic [3:0] second_port_pin_bits_in,
  output logic      [3:0] second_port_pin_bits_out,
  output logic      [3:0] second_port_pin_bits_oe,
  input  wire logic [5:0] first_port_pin_in,
  output logic      [5:0] pin_change_flags,
  output logic            change_summary_irq_flag
);

  // Address decode, used by both the write and the read paths
  function automatic ppcd_sel_e decode(input ppcd_addr_t a);
    case (a)
      `PPCD_OFF_PB_VALUE:  decode = PPCD_SEL_PB_VALUE;
      `PPCD_OFF_PB_DIR:    decode = PPCD_SEL_PB_DIR;
      `PPCD_OFF_RISE_EN:   decode = PPCD_SEL_RISE_EN;
      `PPCD_OFF_FALL_EN:   decode = PPCD_SEL_FALL_EN;
      `PPCD_OFF_CHG_FLAGS: decode = PPCD_SEL_CHG_FLAGS;
      `PPCD_OFF_STATUS:    decode = PPCD_SEL_STATUS;
      default:             decode = PPCD_SEL_NONE;
    endcase
  endfunction : decode

  ppcd_sel_e  wsel;
  ppcd_sel_e  rsel;
  logic [3:0] second_port_output_latch_ff;
  logic [3:0] second_port_direction_ff;
  logic [5:0] rise_edge_enable_ff;
  logic [5:0] fall_edge_enable_ff;
  logic [5:0] pin_change_flags_ff;
  logic [5:0] nxt_pin_change_flags;
  logic [7:0] reg_rdata_ff;
  logic [7:0] nxt_reg_rdata;
  logic [3:0] pb_sync;
  logic [5:0] pa_sync;
  logic [5:0] pa_prev_ff;
  logic [1:0] warm_ff;
  logic       prev_valid_ff;
  logic [5:0] rise_evt;
  logic [5:0] fall_evt;
  logic [5:0] set_evt;

  assign wsel = decode(reg_addr);
  assign rsel = decode(reg_addr);

  // Pin levels pass two flops before any logic reads them
  ppcd_sync #(
    .W (`PPCD_PB_W)
  ) u_pb_sync (
    .clk      (clk),
    .nrst     (nrst),
    .async_in (second_port_pin_bits_in),
    .sync_out (pb_sync)
  );

  ppcd_sync #(
    .W (`PPCD_PA_W)
  ) u_pa_sync (
    .clk      (clk),
    .nrst     (nrst),
    .async_in (first_port_pin_in),
    .sync_out (pa_sync)
  );

  // Output latch takes only the upper nibble of a write
  always_ff @(posedge clk)
  begin
    if (!nrst)
      second_port_output_latch_ff <= `PPCD_PB_LAT_RST;
    else if (reg_wr && wsel == PPCD_SEL_PB_VALUE)
      second_port_output_latch_ff <= reg_wdata[7:4]; // RL1 RL3
  end

  // Direction: every pin an input after any reset
  always_ff @(posedge clk)
  begin
    if (!nrst)
      second_port_direction_ff <= `PPCD_PB_DIR_RST; // RL4
    else if (reg_wr && wsel == PPCD_SEL_PB_DIR)
      second_port_direction_ff <= reg_wdata[7:4]; // RL3
  end

  // Pad drive: a clear direction bit drives the latch onto the pin
  assign second_port_pin_bits_out = second_port_output_latch_ff;
  assign second_port_pin_bits_oe  = ~second_port_direction_ff; // RL4

  // Edge enables
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      rise_edge_enable_ff <= `PPCD_EN_RST; // RL7
      fall_edge_enable_ff <= `PPCD_EN_RST; // RL7
    end
    else if (reg_wr && wsel == PPCD_SEL_RISE_EN)
      rise_edge_enable_ff <= reg_wdata[5:0];
    else if (reg_wr && wsel == PPCD_SEL_FALL_EN)
      fall_edge_enable_ff <= reg_wdata[5:0];
  end

  // Previous sample. The synchroniser restarts at zero, so a pin that idles
  // high would look like a rise; edges count only once the synchroniser and
  // the previous sample both hold real pin levels
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      pa_prev_ff    <= 6'h00;
      warm_ff       <= 2'h0;
      prev_valid_ff <= 1'b0;
    end
    else
    begin
      pa_prev_ff    <= pa_sync;
      warm_ff       <= {warm_ff[0], 1'b1};
      prev_valid_ff <= warm_ff[1]; // RL11
    end
  end

  // One event per transition, since prev catches up the next cycle
  genvar gi;
  generate
    for (gi = 0; gi < `PPCD_PA_W; gi++)
    begin : g_edge
      assign rise_evt[gi] = prev_valid_ff & pa_sync[gi] & ~pa_prev_ff[gi]; // RL11
      assign fall_evt[gi] = prev_valid_ff & ~pa_sync[gi] & pa_prev_ff[gi]; // RL11
      assign set_evt[gi]  = (rise_evt[gi] & rise_edge_enable_ff[gi])    // RL5 RL8
                          | (fall_evt[gi] & fall_edge_enable_ff[gi]);   // RL6 RL7
    end
  endgenerate

  // Software write of zero clears; a same-cycle hardware set wins
  always_comb
  begin
    nxt_pin_change_flags = pin_change_flags_ff;
    if (reg_wr && wsel == PPCD_SEL_CHG_FLAGS)
      nxt_pin_change_flags = pin_change_flags_ff & reg_wdata[5:0]; // RL9
    nxt_pin_change_flags = nxt_pin_change_flags | set_evt; // RL11
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
      pin_change_flags_ff <= `PPCD_FLAG_RST; // RL9
    else
      pin_change_flags_ff <= nxt_pin_change_flags;
  end

  assign pin_change_flags        = pin_change_flags_ff;
  assign change_summary_irq_flag = |pin_change_flags_ff; // RL5 RL6

  // Read mux: unimplemented bits are zero, pins read live levels
  always_comb
  begin
    nxt_reg_rdata = 8'h00;
    case (rsel)
      PPCD_SEL_PB_VALUE:  nxt_reg_rdata = {pb_sync, 4'h0};                  // RL1 RL2
      PPCD_SEL_PB_DIR:    nxt_reg_rdata = {second_port_direction_ff, 4'h0}; // RL3
      PPCD_SEL_RISE_EN:   nxt_reg_rdata = {2'h0, rise_edge_enable_ff};      // RL10
      PPCD_SEL_FALL_EN:   nxt_reg_rdata = {2'h0, fall_edge_enable_ff};      // RL10
      PPCD_SEL_CHG_FLAGS: nxt_reg_rdata = {2'h0, pin_change_flags_ff};      // RL10
      PPCD_SEL_STATUS:    nxt_reg_rdata = {7'h00, change_summary_irq_flag};
      default:            nxt_reg_rdata = 8'h00;
    endcase
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge clk)
  begin
    if (!nrst)
      reg_rdata_ff <= 8'h00;
    else if (reg_rd)
      reg_rdata_ff <= nxt_reg_rdata;
    else
      reg_rdata_ff <= 8'h00;
  end

  assign reg_rdata = reg_rdata_ff;

  // Checks next to the logic
  a_latch_write: assert property (@(posedge clk) disable iff (!nrst) // RL1
    reg_wr && reg_addr == `PPCD_OFF_PB_VALUE |=>
      second_port_output_latch_ff == $past(reg_wdata[7:4]))
    else $error("latch did not take write");

  a_pin_read: assert property (@(posedge clk) disable iff (!nrst) // RL2
    reg_rd && reg_addr == `PPCD_OFF_PB_VALUE |=> reg_rdata[7:4] == $past(pb_sync))
    else $error("port read not pin level");

  a_low_nibble_zero: assert property (@(posedge clk) disable iff (!nrst) // RL3
    reg_rdata[3:0] == 4'h0 || $past(reg_addr) >= `PPCD_OFF_RISE_EN)
    else $error("low nibble not zero");

  a_dir_drive: assert property (@(posedge clk) disable iff (!nrst) // RL4
    reg_wr && reg_addr == `PPCD_OFF_PB_DIR |=>
      second_port_pin_bits_oe == ~$past(reg_wdata[7:4]))
    else $error("output enable wrong");

  a_rise_sets: assert property (@(posedge clk) disable iff (!nrst) // RL5
    rise_edge_enable_ff[0] && $rose(pa_sync[0]) && prev_valid_ff |=>
      pin_change_flags_ff[0] && change_summary_irq_flag)
    else $error("rising edge lost");

  a_fall_sets: assert property (@(posedge clk) disable iff (!nrst) // RL6
    fall_edge_enable_ff[0] && $fell(pa_sync[0]) && prev_valid_ff |=>
      pin_change_flags_ff[0])
    else $error("falling edge lost");

  a_no_set_disabled: assert property (@(posedge clk) disable iff (!nrst) // RL7
    !rise_edge_enable_ff[0] && !fall_edge_enable_ff[0] && !pin_change_flags_ff[0]
      |=> !pin_change_flags_ff[0])
    else $error("disabled pin flagged");

  a_flag_sticky: assert property (@(posedge clk) disable iff (!nrst) // RL9
    pin_change_flags_ff[1] && !(reg_wr && reg_addr == `PPCD_OFF_CHG_FLAGS)
      |=> pin_change_flags_ff[1])
    else $error("flag dropped by itself");

  a_upper_zero: assert property (@(posedge clk) disable iff (!nrst) // RL10
    reg_rd && reg_addr == `PPCD_OFF_CHG_FLAGS |=> reg_rdata[7:6] == 2'h0)
    else $error("bits 7 and 6 not zero");

  a_set_beats_clr: assert property (@(posedge clk) disable iff (!nrst) // RL11
    set_evt[2] |=> pin_change_flags_ff[2])
    else $error("set lost to clear");

  // Every kind of reset leaves inputs, no enables and no flags
  a_dir_reset: assert property (@(posedge clk) disable iff (!nrst) // RL4
    !$past(nrst) |-> second_port_direction_ff == `PPCD_PB_DIR_RST)
    else $error("direction not reset to input");

  a_en_reset: assert property (@(posedge clk) disable iff (!nrst) // RL7
    !$past(nrst) |->
      rise_edge_enable_ff == `PPCD_EN_RST && fall_edge_enable_ff == `PPCD_EN_RST)
    else $error("edge enables not reset");

  a_flag_reset: assert property (@(posedge clk) disable iff (!nrst) // RL9
    !$past(nrst) |-> pin_change_flags_ff == `PPCD_FLAG_RST && !change_summary_irq_flag)
    else $error("change flags not reset");

  // A pin that idles high must not look like a rise once reset lets go
  a_warmup_quiet: assert property (@(posedge clk) disable iff (!nrst) // RL11
    !$past(nrst, 3) |-> set_evt == 6'h00)
    else $error("edge seen during warm-up");

  // Only a detected edge may raise the summary; software cannot set it
  a_summary_src: assert property (@(posedge clk) disable iff (!nrst) // RL5 RL6
    $rose(change_summary_irq_flag) |-> $past(set_evt) != 6'h00)
    else $error("summary rose without edge");

  a_status_read: assert property (@(posedge clk) disable iff (!nrst) // RL5 RL6
    reg_rd && reg_addr == `PPCD_OFF_STATUS |=>
      reg_rdata == {7'h00, $past(change_summary_irq_flag)})
    else $error("status read wrong");

  // Edges on other pins, so more than one lane is watched
  a_rise_flags: assert property (@(posedge clk) disable iff (!nrst) // RL5 RL8
    rise_edge_enable_ff[5] && $rose(pa_sync[5]) && prev_valid_ff |=>
      pin_change_flags_ff[5] && change_summary_irq_flag)
    else $error("rising edge lost on pin 5");

  a_fall_flags: assert property (@(posedge clk) disable iff (!nrst) // RL6 RL8
    fall_edge_enable_ff[3] && $fell(pa_sync[3]) && prev_valid_ff |=>
      pin_change_flags_ff[3] && change_summary_irq_flag)
    else $error("falling edge lost on pin 3");

  // A disabled polarity leaves a clear flag clear
  a_no_rise_dis: assert property (@(posedge clk) disable iff (!nrst) // RL7
    !rise_edge_enable_ff[4] && $rose(pa_sync[4]) && !pin_change_flags_ff[4] |=>
      !pin_change_flags_ff[4])
    else $error("disabled rise flagged");

  a_no_fall_dis: assert property (@(posedge clk) disable iff (!nrst) // RL7
    !fall_edge_enable_ff[1] && $fell(pa_sync[1]) && !pin_change_flags_ff[1] |=>
      !pin_change_flags_ff[1])
    else $error("disabled fall flagged");

  // Enable writes keep the six implemented bits
  a_rise_en_write: assert property (@(posedge clk) disable iff (!nrst) // RL5
    reg_wr && reg_addr == `PPCD_OFF_RISE_EN |=>
      rise_edge_enable_ff == $past(reg_wdata[5:0]))
    else $error("rise enable write lost");

  a_fall_en_write: assert property (@(posedge clk) disable iff (!nrst) // RL6
    reg_wr && reg_addr == `PPCD_OFF_FALL_EN |=>
      fall_edge_enable_ff == $past(reg_wdata[5:0]))
    else $error("fall enable write lost");

  a_clear_works: assert property (@(posedge clk) disable iff (!nrst) // RL9
    reg_wr && reg_addr == `PPCD_OFF_CHG_FLAGS && !reg_wdata[3] && !set_evt[3] |=>
      !pin_change_flags_ff[3])
    else $error("flag not cleared by zero");

  // Latch and direction registers move only on their own write
  a_latch_hold: assert property (@(posedge clk) disable iff (!nrst) // RL1
    !(reg_wr && reg_addr == `PPCD_OFF_PB_VALUE) |=> $stable(second_port_output_latch_ff))
    else $error("latch changed without write");

  a_dir_hold: assert property (@(posedge clk) disable iff (!nrst) // RL4
    !(reg_wr && reg_addr == `PPCD_OFF_PB_DIR) |=> $stable(second_port_direction_ff))
    else $error("direction changed without write");

  a_dir_read: assert property (@(posedge clk) disable iff (!nrst) // RL3 RL4
    reg_rd && reg_addr == `PPCD_OFF_PB_DIR |=>
      reg_rdata == {$past(second_port_direction_ff), 4'h0})
    else $error("direction read wrong");

  a_en_upper_zero: assert property (@(posedge clk) disable iff (!nrst) // RL10
    reg_rd && (reg_addr == `PPCD_OFF_RISE_EN || reg_addr == `PPCD_OFF_FALL_EN) |=>
      reg_rdata[7:6] == 2'h0)
    else $error("enable bits 7 and 6 not zero");

  // A steady pin gives no second event
  a_one_event: assert property (@(posedge clk) disable iff (!nrst) // RL11
    set_evt[5] ##1 $stable(pa_sync[5]) |-> !set_evt[5])
    else $error("one transition flagged twice");

endmodule : ppcd_top

// ### verification/ppcd_board.sv
/*
  Board model for the port pins: resolves the second-port pins and drives
  the first-port pins. Assumes the bench sets the board levels.
*/
`timescale 1ns/1ns

module ppcd_board
(
  input  wire logic [3:0] pb_out,
  input  wire logic [3:0] pb_oe,
  input  wire logic [3:0] pb_ext,
  input  wire logic [5:0] pa_lvl,
  output logic      [3:0] pb_pin,
  output logic      [5:0] pa_pin
);
  // A driven pin shows the latch, an undriven one the board level
  assign pb_pin = (pb_oe & pb_out) | (~pb_oe & pb_ext);
  // First-port pins are plain board inputs, no pull
  assign pa_pin = pa_lvl;
endmodule : ppcd_board

// ### verification/ppcd_top_tb.sv
/*
  Self-checking bench for the port pins and change detect block.
  Assumes the board model and a 250 MHz clock made here.
*/
`timescale 1ns/1ns
`include "ppcd_regs.svh"

module ppcd_top_tb
  import ppcd_pkg::*;
;
  logic        clk, nrst, reg_wr, reg_rd, summ;
  ppcd_addr_t  reg_addr;
  ppcd_byte_t  reg_wdata, reg_rdata, d, dr, r, f, w;
  logic [3:0]  pb_out, pb_oe, pb_ext, pb_pin;
  logic [5:0]  pa_lvl, pa_pin, flags, a, e;
  logic [15:0] lf;
  int          n_fail, cmp_count;

  ppcd_top ppcd_top_i (.clk(clk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .second_port_pin_bits_in(pb_pin),
    .second_port_pin_bits_out(pb_out), .second_port_pin_bits_oe(pb_oe),
    .first_port_pin_in(pa_pin), .pin_change_flags(flags),
    .change_summary_irq_flag(summ));
  ppcd_board ppcd_board_i (.pb_out(pb_out), .pb_oe(pb_oe), .pb_ext(pb_ext),
    .pa_lvl(pa_lvl), .pb_pin(pb_pin), .pa_pin(pa_pin));

  // 4 ns clock
  always #2 clk = ~clk;

  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : lfsr

  // Expected flags from the old and new pin levels and both enables
  function automatic logic [5:0] edges(input logic [5:0] o, n, re, fe);
    return (~o & n & re) | (o & ~n & fe);
  endfunction : edges

  // Expected pin levels: a driven pin shows the latch, others the board
  function automatic logic [3:0] pins(input logic [3:0] lat, dir, ext);
    return (~dir & lat) | (dir & ext);
  endfunction : pins

  task automatic chk(input ppcd_byte_t seen, exp, input string what);
    cmp_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("wrong value %s exp %h seen %h", what, exp, seen);
    end
  endtask : chk

  // Write, then a gap cycle so strobes never retoggle in one step
  task automatic wr(input ppcd_addr_t ad, input ppcd_byte_t dt);
    reg_addr  <= ad;
    reg_wdata <= dt;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rd(input ppcd_addr_t ad, input ppcd_byte_t exp);
    reg_addr <= ad;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp, "read data");
    @(posedge clk);
  endtask : rd

  task automatic conclude;
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : conclude

  // Cuts a hang short, far beyond the expected run
  initial
  begin
    #40000;
    n_fail++;
    conclude();
  end

  initial
  begin
    clk = 0; nrst = 0; reg_wr = 0; reg_rd = 0; reg_addr = 0; reg_wdata = 0;
    pb_ext = 4'h5; pa_lvl = 6'h00; lf = 16'hd725; n_fail = 0; cmp_count = 0;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    // Reset values, unmapped writes dropped
    wr(3'h6, 8'hff);
    wr(3'h7, 8'hff);
    rd(`PPCD_OFF_PB_VALUE, 8'h50);
    rd(`PPCD_OFF_PB_DIR, 8'hf0);
    rd(`PPCD_OFF_RISE_EN, 8'h00);
    rd(`PPCD_OFF_FALL_EN, 8'h00);
    rd(`PPCD_OFF_CHG_FLAGS, 8'h00);
    rd(3'h6, 8'h00);
    rd(3'h7, 8'h00);
    #1;
    chk({4'h0, pb_oe}, 8'h00, "drive enable");
    @(posedge clk);
    $display("reset test done");
    // Latch, direction and live pin reads
    for (int i = 0; i < 8; i++)
    begin
      lf = lfsr(lf);
      d  = (i == 0) ? 8'hff : lf[7:0];
      dr = (i == 0) ? 8'h00 : lf[15:8];
      wr(`PPCD_OFF_PB_VALUE, d);
      wr(`PPCD_OFF_PB_DIR, dr);
      pb_ext <= lf[11:8] ^ 4'ha;
      repeat (3) @(posedge clk);
      #1;
      chk({4'h0, pb_out}, {4'h0, d[7:4]}, "latch");
      chk({4'h0, pb_oe}, {4'h0, ~dr[7:4]}, "drive enable");
      @(posedge clk);
      rd(`PPCD_OFF_PB_DIR, dr & 8'hf0);
      rd(`PPCD_OFF_PB_VALUE, {pins(d[7:4], dr[7:4], pb_ext), 4'h0});
    end
    $display("port test done");
    // Edge detection, sticky flags, partial clears
    for (int i = 0; i < 12; i++)
    begin
      lf = lfsr(lf);
      r  = (i == 0) ? 8'h00 : lf[7:0];
      f  = (i == 0) ? 8'h00 : lf[15:8];
      wr(`PPCD_OFF_RISE_EN, r);
      wr(`PPCD_OFF_FALL_EN, f);
      wr(`PPCD_OFF_CHG_FLAGS, 8'h00);
      lf = lfsr(lf);
      a = pa_lvl;
      e = edges(a, lf[5:0], r[5:0], f[5:0]);
      pa_lvl <= lf[5:0];
      repeat (5) @(posedge clk);
      #1;
      chk({2'h0, flags}, {2'h0, e}, "flags");
      chk({7'h0, summ}, {7'h0, |e}, "summary");
      @(posedge clk);
      rd(`PPCD_OFF_RISE_EN, r & 8'h3f);
      rd(`PPCD_OFF_FALL_EN, f & 8'h3f);
      rd(`PPCD_OFF_CHG_FLAGS, {2'h0, e});
      rd(`PPCD_OFF_STATUS, {7'h0, |e});
      lf = lfsr(lf);
      w  = lf[10:3];
      wr(`PPCD_OFF_CHG_FLAGS, w);
      rd(`PPCD_OFF_CHG_FLAGS, {2'h0, e & w[5:0]});
    end
    $display("edge test done");
    // Set beats a clear in the same cycle; then a reset with pins held high
    wr(`PPCD_OFF_RISE_EN, 8'hff);
    wr(`PPCD_OFF_FALL_EN, 8'hff);
    wr(`PPCD_OFF_CHG_FLAGS, 8'h00);
    a = pa_lvl;
    e = edges(a, ~a, 6'h3f, 6'h3f);
    pa_lvl <= ~a;
    repeat (2) @(posedge clk);
    wr(`PPCD_OFF_CHG_FLAGS, 8'h00);
    #1;
    chk({2'h0, flags}, {2'h0, e}, "set over clear");
    @(posedge clk);
    nrst   <= 1'b0;
    pa_lvl <= 6'h3f;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    wr(`PPCD_OFF_RISE_EN, 8'hff);
    repeat (6) @(posedge clk);
    #1;
    chk({2'h0, flags}, 8'h00, "flags after reset");
    chk({4'h0, pb_oe}, 8'h00, "drive enable after reset");
    @(posedge clk);
    rd(`PPCD_OFF_PB_DIR, 8'hf0);
    rd(`PPCD_OFF_FALL_EN, 8'h00);
    $display("corner test done");
    conclude();
  end
endmodule : ppcd_top_tb
